// [src/two_wire_eeprom.sv]
/*
 * Two-wire serial EEPROM target: pin capture on the serial clock, a core-clock
 * engine for addressing, page writes and reads, and the self-timed write cycle.
 * Assumes a 125 MHz core clock, an external pull-up on the data wire and that
 * the bench resolves the wire from sdaOe; the serial clock is idle high.
 */
// Contract
// - Capture data on serial clock rising edge.
// - Change driven data only after falling edge.
// - Data wire open-drain: pull low or release.
// - Write-lock low: array writes proceed normally.
// - Write-lock high: no array write at all.
// - Undriven write-lock reads as low, unprotected.
// - Page writes up to 16 bytes, partial allowed.
// - Self-timed programming finishes within 5 ms.
// - Array of 2,048 bytes, eleven-bit address.
// - Random reads and sequential reads supported.
// - Works at 100 kHz, 400 kHz, 1 MHz.
`timescale 1ns/100ps
`default_nettype none
module two_wire_eeprom #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic wpIn
);
	// Last value of the write-cycle counter.
	localparam logic [eeprom_pkg::PROG_W-1:0] PROG_LAST =
		eeprom_pkg::PROG_W'(WRITE_CYCLES - 1);
	localparam logic [eeprom_pkg::PROG_W-1:0] PROG_COPY =
		eeprom_pkg::PROG_W'(eeprom_pkg::PAGE_BYTES);

	// Serial clock domain: sample register and the falling-edge drive flop.
	eeprom_pkg::linkSample_t lk_r;
	eeprom_pkg::linkSample_t lk_nxt;
	logic drv_r;
	logic drv_nxt;

	// Core domain state and helpers.
	eeprom_pkg::core_t st_r;
	eeprom_pkg::core_t st_nxt;
	// Synchronised pins and event toggle, in core clock order.
	logic [3:0] syncOut;
	logic sclS; // Serial clock level.
	logic sdaS; // Data wire level.
	logic wpLock; // Write lock in force.
	logic tglS; // Bit event toggle.
	// Decoded events of the current core cycle.
	logic bitEvt; // A rising serial clock edge has landed.
	logic startEvt; // Start or repeated start seen.
	logic stopEvt; // Stop seen.
	// Byte assembled so far with the newest bit appended.
	logic [7:0] rxByte;
	// Page slot copied in the current programming step.
	logic [3:0] copyIdx;
	// Registered read words of the array and of the page buffer.
	logic [7:0] arrRd;
	logic [7:0] bufRd;
	// Write requests into the array and the page buffer.
	eeprom_pkg::memWr_t arrWr;
	eeprom_pkg::memWr_t bufWr;

	// Each rising edge takes one bit from the wire and flips the event toggle.
	always_comb begin
		lk_nxt.val = sdaIn;
		lk_nxt.tgl = ~lk_r.tgl;
	end

	always_ff @(posedge scl or negedge rst_b) begin
		if (!rst_b) begin
			lk_r <= '0;
		end else begin
			lk_r <= lk_nxt;
		end
	end

	// The engine settles its drive level well inside the clock high time, so
	// this falling-edge flop takes a stable word and is the only pin driver.
	always_comb begin
		drv_nxt = st_r.driveLow;
	end

	always_ff @(negedge scl or negedge rst_b) begin
		if (!rst_b) begin
			drv_r <= 1'b0;
		end else begin
			drv_r <= drv_nxt;
		end
	end

	// Open drain: the pin only ever pulls low; high comes from the pull-up.
	assign sdaOut = 1'b0;
	assign sdaOe = drv_r;

	// Pins and the event toggle cross into the core clock through two flops.
	// Three cycles of 8 ns lag is far below the shortest clock phase at 1 MHz.
	sig_sync #(
		.W(4)
	) u_sync (
		.clk(mclk),
		.rst_b(rst_b),
		.din({scl, sdaIn, wpIn, lk_r.tgl}),
		.dout(syncOut)
	);

	assign sclS = syncOut[3];
	assign sdaS = syncOut[2];
	// Only a firm high locks; a floating pin is pulled low and allows writes.
	assign wpLock = (syncOut[1] == 1'b1);
	assign tglS = syncOut[0];

	// Edge decode on synchronised levels only.
	assign bitEvt = tglS != st_r.tglD;
	assign startEvt = sclS && st_r.sclD && st_r.sdaD && !sdaS;
	assign stopEvt = sclS && st_r.sclD && !st_r.sdaD && sdaS;
	// The sampled bit is steady for a whole clock period once its toggle lands.
	assign rxByte = {st_r.shift[6:0], lk_r.val};
	assign copyIdx = st_r.progCnt[3:0] - 4'h1;

	// The array: 2,048 bytes read at the current address.
	eeprom_mem #(
		.AW(eeprom_pkg::ADDR_W)
	) u_array (
		.clk(mclk),
		.rst_b(rst_b),
		.wrEn(arrWr.en),
		.wrAddr(arrWr.addr),
		.wrData(arrWr.data),
		.rdAddr(st_r.addr),
		.rdData(arrRd)
	);

	// The page buffer collects up to 16 bytes before programming.
	eeprom_mem #(
		.AW(eeprom_pkg::PAGE_W)
	) u_page (
		.clk(mclk),
		.rst_b(rst_b),
		.wrEn(bufWr.en),
		.wrAddr(bufWr.addr[eeprom_pkg::PAGE_W-1:0]),
		.wrData(bufWr.data),
		.rdAddr(st_r.progCnt[3:0]),
		.rdData(bufRd)
	);

	// Core engine: programming, then start, stop and bit events by priority.
	always_comb begin
		st_nxt = st_r;
		st_nxt.sclD = sclS;
		st_nxt.sdaD = sdaS;
		st_nxt.tglD = tglS;
		arrWr = '0;
		bufWr = '0;
		// Self-timed cycle: copy marked bytes first, then wait out the time.
		if (st_r.busy) begin
			st_nxt.progCnt = st_r.progCnt + 1'b1;
			if (st_r.progCnt != '0 && st_r.progCnt <= PROG_COPY) begin
				// A lock raised mid-cycle still stops the remaining bytes.
				arrWr.en = st_r.valid[copyIdx] && !wpLock;
				arrWr.addr = {st_r.addr[10:4], copyIdx};
				arrWr.data = bufRd;
			end
			if (st_r.progCnt == PROG_LAST) begin
				st_nxt.busy = 1'b0;
				st_nxt.progCnt = '0;
				st_nxt.valid = '0;
			end
		end
		if (startEvt) begin
			// Start or repeated start: listen for a control byte.
			st_nxt.st = eeprom_pkg::ST_CTRL;
			st_nxt.bitCnt = 4'h0;
			st_nxt.driveLow = 1'b0;
		end else if (stopEvt) begin
			// A stop after accepted data launches the write cycle.
			if (st_r.st == eeprom_pkg::ST_WDATA && |st_r.valid && !wpLock) begin
				st_nxt.busy = 1'b1;
				st_nxt.progCnt = '0;
			end
			st_nxt.st = eeprom_pkg::ST_IDLE;
			st_nxt.driveLow = 1'b0;
		end else if (bitEvt && st_r.st != eeprom_pkg::ST_IDLE) begin
			st_nxt.bitCnt = st_r.bitCnt + 4'h1;
			if (st_r.bitCnt == eeprom_pkg::ACK_SLOT) begin
				// Acknowledge slot over: release, or load the next read byte.
				st_nxt.bitCnt = 4'h0;
				st_nxt.driveLow = 1'b0;
				if (st_r.st == eeprom_pkg::ST_RDATA) begin
					if (lk_r.val) begin
						// Controller declined: the read ends here.
						st_nxt.st = eeprom_pkg::ST_IDLE;
					end else begin
						st_nxt.shift = arrRd;
						st_nxt.driveLow = ~arrRd[7];
					end
				end
			end else if (st_r.st == eeprom_pkg::ST_RDATA) begin
				// Send the next bit; after the eighth, release for the answer.
				st_nxt.shift = {st_r.shift[6:0], 1'b1};
				st_nxt.driveLow = (st_r.bitCnt != eeprom_pkg::LAST_BIT) && !st_r.shift[6];
				if (st_r.bitCnt == eeprom_pkg::LAST_BIT) begin
					// The counter runs over the whole array and wraps.
					st_nxt.addr = st_r.addr + 1'b1;
				end
			end else begin
				st_nxt.shift = rxByte;
				if (st_r.bitCnt == eeprom_pkg::LAST_BIT) begin
					case (st_r.st)
						eeprom_pkg::ST_CTRL: begin
							// Busy programming: stay silent so polling sees no answer.
							if (rxByte[7:4] == eeprom_pkg::DEV_TYPE && !st_r.busy) begin
								st_nxt.driveLow = 1'b1;
								if (rxByte[0]) begin
									st_nxt.st = eeprom_pkg::ST_RDATA;
								end else begin
									st_nxt.ctrlHi = rxByte[3:1];
									st_nxt.st = eeprom_pkg::ST_ADDR;
								end
							end else begin
								st_nxt.st = eeprom_pkg::ST_IDLE;
							end
						end
						eeprom_pkg::ST_ADDR: begin
							// Full address: three bits from control, eight from here.
							st_nxt.addr = {st_r.ctrlHi, rxByte};
							st_nxt.valid = '0;
							st_nxt.driveLow = 1'b1;
							st_nxt.st = eeprom_pkg::ST_WDATA;
						end
						eeprom_pkg::ST_WDATA: begin
							// Locked bytes are refused and never reach the buffer.
							if (!wpLock) begin
								bufWr.en = 1'b1;
								bufWr.addr = {7'h00, st_r.addr[3:0]};
								bufWr.data = rxByte;
								st_nxt.valid[st_r.addr[3:0]] = 1'b1;
								// Low nibble wraps inside the page.
								st_nxt.addr[3:0] = st_r.addr[3:0] + 4'h1;
								st_nxt.driveLow = 1'b1;
							end
						end
						default: begin
							st_nxt.st = eeprom_pkg::ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// Core state register.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{st: eeprom_pkg::ST_IDLE, sclD: 1'b1, sdaD: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Checks on the behaviour of the pins and of the engine.
	AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (!rst_b)
		sdaOut == 1'b0) else $error("data pin drives high");
	AST_DRIVE_ON_FALL: assert property (@(posedge mclk) disable iff (!rst_b)
		$changed(sdaOe) |-> ##[1:4] !sclS) else $error("data changed outside low clock");
	AST_CAPTURE_RISE: assert property (@(posedge scl) disable iff (!rst_b)
		1'b1 |=> lk_r.val == $past(sdaIn)) else $error("bit not taken on rising edge");
	AST_LOCK_NO_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
		arrWr.en |-> !wpLock) else $error("array written while locked");
	AST_UNLOCK_PROGRAMS: assert property (@(posedge mclk) disable iff (!rst_b)
		(stopEvt && !startEvt && st_r.st == eeprom_pkg::ST_WDATA && |st_r.valid && !wpLock)
		|=> st_r.busy) else $error("write cycle not started");
	AST_WRITE_TIME: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(st_r.busy) |-> $past(st_r.progCnt) == PROG_LAST) else $error("write cycle length");
	AST_PAGE_WRAP: assert property (@(posedge mclk) disable iff (!rst_b)
		bufWr.en |=> st_r.addr == {$past(st_r.addr[10:4]), $past(st_r.addr[3:0]) + 4'h1})
		else $error("page address did not wrap in page");
	AST_SEQ_READ: assert property (@(posedge mclk) disable iff (!rst_b)
		(bitEvt && !startEvt && !stopEvt && st_r.st == eeprom_pkg::ST_RDATA
		&& st_r.bitCnt == eeprom_pkg::LAST_BIT) |=> st_r.addr == $past(st_r.addr) + 11'h001)
		else $error("read address did not advance");
	// The control byte that ends while programming runs must go unanswered.
	AST_BUSY_SILENT: assert property (@(posedge mclk) disable iff (!rst_b)
		(st_r.busy && bitEvt && !startEvt && !stopEvt
		&& st_r.st == eeprom_pkg::ST_CTRL && st_r.bitCnt == eeprom_pkg::LAST_BIT)
		|=> (!st_r.driveLow && st_r.st == eeprom_pkg::ST_IDLE))
		else $error("answered while programming");
	// A locked data byte is neither answered nor marked for programming.
	AST_LOCK_REFUSE: assert property (@(posedge mclk) disable iff (!rst_b)
		(bitEvt && !startEvt && !stopEvt && st_r.st == eeprom_pkg::ST_WDATA
		&& st_r.bitCnt == eeprom_pkg::LAST_BIT && wpLock)
		|=> (!st_r.driveLow && $stable(st_r.valid))) else $error("locked byte accepted");

	COV_PROGRAM: cover property (@(posedge mclk) disable iff (!rst_b) $rose(st_r.busy));
	COV_READ_BYTE: cover property (@(posedge mclk) disable iff (!rst_b)
		st_r.st == eeprom_pkg::ST_RDATA && st_r.bitCnt == eeprom_pkg::ACK_SLOT);
	COV_POLL_NACK: cover property (@(posedge mclk) disable iff (!rst_b)
		st_r.busy && st_r.st == eeprom_pkg::ST_CTRL && bitEvt
		&& st_r.bitCnt == eeprom_pkg::LAST_BIT);
	COV_LOCK_REFUSED: cover property (@(posedge mclk) disable iff (!rst_b)
		bitEvt && st_r.st == eeprom_pkg::ST_WDATA
		&& st_r.bitCnt == eeprom_pkg::LAST_BIT && wpLock);
	COV_READ_WRAP: cover property (@(posedge mclk) disable iff (!rst_b)
		bitEvt && st_r.st == eeprom_pkg::ST_RDATA && st_r.addr == 11'h7FF
		&& st_r.bitCnt == eeprom_pkg::LAST_BIT);
endmodule : two_wire_eeprom
`default_nettype wire

// [pkg/eeprom_pkg.sv]
/*
 * Shared constants and types of the two-wire EEPROM target: array geometry,
 * device type code, write-cycle timing, bus engine states and carrier structs.
 * Assumes a core clock of 125 MHz; every user refers to names as eeprom_pkg::name.
 */
package eeprom_pkg;
	// Array of 2,048 bytes, so an eleven-bit byte address.
	localparam int ADDR_W = 11;
	// Page of 16 bytes, addressed by the low four address bits.
	localparam int PAGE_W = 4;
	localparam int PAGE_BYTES = 16;
	// Upper nibble of the control byte that selects this memory.
	localparam logic [3:0] DEV_TYPE = 4'hA;
	// Bit counter value of the last data bit and of the acknowledge slot.
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// Core clock period in picoseconds (125 MHz).
	localparam int CLK_PERIOD_PS = 8000;
	// Longest self-timed write cycle, in nanoseconds.
	localparam longint WRITE_TIME_NS = 5000000;
	// Longest time rounds down to whole core cycles.
	localparam int WRITE_CYC = int'((WRITE_TIME_NS * 1000) / CLK_PERIOD_PS);
	// Width of the write-cycle counter.
	localparam int PROG_W = 20;

	// Serial engine states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CTRL = 5'h02,
		ST_ADDR = 5'h04,
		ST_WDATA = 5'h08,
		ST_RDATA = 5'h10
	} busState_t;

	// One write into a memory.
	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} memWr_t;

	// Bit captured on the serial clock rising edge, with its event toggle.
	typedef struct packed {
		logic val;
		logic tgl;
	} linkSample_t;

	// Whole state of the core-clock engine.
	typedef struct packed {
		busState_t st;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [ADDR_W-1:0] addr;
		logic [2:0] ctrlHi;
		logic driveLow;
		logic [PAGE_BYTES-1:0] valid;
		logic busy;
		logic [PROG_W-1:0] progCnt;
		logic sclD;
		logic sdaD;
		logic tglD;
	} core_t;
endpackage : eeprom_pkg

// [src/sig_sync.sv]
/*
 * Two flip-flop level synchroniser for a bundle of independent levels.
 * Assumes each bit changes slowly against the destination clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sig_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// Both stages; the first is read only by the second.
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} syncState_t;

	syncState_t st_r;
	syncState_t st_nxt;

	// Next state: shift the levels one stage along.
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
	end

	// Registers, cleared to a constant under reset.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.s2;
endmodule : sig_sync
`default_nettype wire

// [src/eeprom_mem.sv]
/*
 * Simple dual-port byte memory with a registered read port.
 * Assumes one write and one read per clock; read data follow one cycle later.
 */
`timescale 1ns/100ps
`default_nettype none
module eeprom_mem #(
	parameter int AW = 11
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [7:0] rdData
);
	// Storage cells; no reset, as a real array keeps its contents.
	logic [7:0] mem [0:(1<<AW)-1];
	// Registered read word.
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;

	// Storage write port.
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Read data come from a flop, so the output never glitches.
	always_comb begin
		rdData_nxt = mem[rdAddr];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_r <= 8'h00;
		end else begin
			rdData_r <= rdData_nxt;
		end
	end

	assign rdData = rdData_r;
endmodule : eeprom_mem
`default_nettype wire

// [test/i2c_ctrl_model.sv]
/*
 * Behavioural two-wire bus controller: drives the serial clock and pulls the data wire low.
 * Assumes the bench resolves the wire with a pull-up and calls one task at a time.
 */
`timescale 1ns/100ps
`default_nettype none
module i2c_ctrl_model (
	output logic scl,
	output logic sdaLow,
	input wire logic sda
);
	// Half clock period in ns; kept above the 100 ns phase minimum of the target.
	int halfNs = 250;
	// The clock idles high and the wire is released outside frames.
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// One bit slot: data moves only while the clock is low, sampled in mid-high.
	task automatic bit_c(input logic b, output logic r);
		#40;
		sdaLow = ~b;
		#(halfNs - 40);
		scl = 1'b1;
		#(halfNs / 2);
		r = sda;
		#(halfNs - halfNs / 2);
		scl = 1'b0;
	endtask : bit_c
	// Start or repeated start: the wire falls while the clock is high.
	task automatic start_c();
		#40;
		sdaLow = 1'b0;
		#(halfNs - 40);
		scl = 1'b1;
		#(halfNs);
		sdaLow = 1'b1;
		#(halfNs);
		scl = 1'b0;
	endtask : start_c
	// Stop: the wire rises while the clock is high, then the bus stays idle.
	task automatic stop_c();
		#40;
		sdaLow = 1'b1;
		#(halfNs - 40);
		scl = 1'b1;
		#(halfNs);
		sdaLow = 1'b0;
		#(halfNs);
	endtask : stop_c
	// Sends a byte, most significant bit first, and returns the target's acknowledge.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_c(d[i], r);
		end
		bit_c(1'b1, r);
		ack = ~r;
	endtask : wr_byte
	// Receives a byte and acknowledges it when more bytes are wanted.
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_c(1'b1, d[i]);
		end
		bit_c(~more, r);
	endtask : rd_byte
endmodule : i2c_ctrl_model
`default_nettype wire

// [test/two_wire_eeprom_bench.sv]
/*
 * Self-checking bench of the two-wire EEPROM target with a behavioural bus controller.
 * Assumes a short write cycle parameter; a byte model of the array predicts every read.
 */
`timescale 1ns/100ps
`default_nettype none
module two_wire_eeprom_bench;
	// Short write cycle keeps polling fast while still showing a busy phase.
	localparam int WC = 2000;
	logic mclk, rst_b, wpDrv, sdaOut, sdaOe, scl, sdaLow;
	// The lock pin has a pull-down, so an undriven pin reads low.
	tri0 wpNet;
	wire sda;
	int errors = 0;
	int testsRun = 0;
	logic [7:0] refMem [2048];
	assign wpNet = wpDrv;
	// Wired-AND with a pull-up: high unless some party pulls low.
	assign sda = ~(sdaOe | sdaLow);
	two_wire_eeprom #(.WRITE_CYCLES(WC)) two_wire_eeprom_inst (.mclk(mclk), .rst_b(rst_b),
		.scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .wpIn(wpNet));
	i2c_ctrl_model i2c_ctrl_model_inst (.scl(scl), .sdaLow(sdaLow), .sda(sda));
	// Core clock of 8 ns.
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Compares a seen value with the expected one and counts both.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		testsRun++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	// The device may move the wire only while the clock is low, and only by pulling low.
	always @(sdaOe) begin
		if (rst_b === 1'b1) begin
			check({7'h00, scl}, 8'h00, "wire moved with clock high");
			check({7'h00, sdaOut}, 8'h00, "wire driven high");
		end
	end
	function automatic logic [7:0] ctrl(input logic [10:0] a, input logic rd);
		return {eeprom_pkg::DEV_TYPE, a[10:8], rd};
	endfunction : ctrl
	// Acknowledge polling; a busy device nacks, and the cycle ends within four polls.
	task automatic poll(input logic busy);
		logic ack;
		int k;
		k = 0;
		ack = 1'b0;
		while (!ack && k < 4) begin
			i2c_ctrl_model_inst.start_c();
			i2c_ctrl_model_inst.wr_byte(ctrl(11'h000, 1'b0), ack);
			i2c_ctrl_model_inst.stop_c();
			if (k == 0) check({7'h00, ack}, {7'h00, ~busy}, "first poll");
			k++;
		end
		check({7'h00, ack}, 8'h01, "write cycle end");
	endtask : poll
	// Writes n bytes base, base+1 and on from a; locked data bytes must be refused.
	task automatic wr_page(input logic [10:0] a, input int n, input logic [7:0] base,
		input logic lock);
		logic ack;
		i2c_ctrl_model_inst.start_c();
		i2c_ctrl_model_inst.wr_byte(ctrl(a, 1'b0), ack);
		check({7'h00, ack}, 8'h01, "control ack");
		i2c_ctrl_model_inst.wr_byte(a[7:0], ack);
		check({7'h00, ack}, 8'h01, "address ack");
		for (int i = 0; i < n; i++) begin
			i2c_ctrl_model_inst.wr_byte(base + 8'(i), ack);
			check({7'h00, ack}, {7'h00, ~lock}, "data ack");
			// Addresses wrap inside the 16-byte page.
			if (!lock) refMem[{a[10:4], a[3:0] + 4'(i)}] = base + 8'(i);
		end
		i2c_ctrl_model_inst.stop_c();
		poll(~lock && (i2c_ctrl_model_inst.halfNs * 21 < WC * 8));
	endtask : wr_page
	// Random read from a, then further bytes in sequence, the model address wrapping at 11 bits.
	task automatic rd_chk(input logic [10:0] a, input int n);
		logic ack;
		logic [7:0] d;
		i2c_ctrl_model_inst.start_c();
		i2c_ctrl_model_inst.wr_byte(ctrl(a, 1'b0), ack);
		i2c_ctrl_model_inst.wr_byte(a[7:0], ack);
		i2c_ctrl_model_inst.start_c();
		i2c_ctrl_model_inst.wr_byte(ctrl(a, 1'b1), ack);
		check({7'h00, ack}, 8'h01, "read control ack");
		for (int i = 0; i < n; i++) begin
			i2c_ctrl_model_inst.rd_byte(i < n - 1, d);
			check(d, refMem[a + 11'(i)], "read data");
		end
		i2c_ctrl_model_inst.stop_c();
	endtask : rd_chk
	// A page of 18 bytes: the last two wrap and overwrite the first two.
	task automatic t_page();
		wr_page(11'h7F0, 18, 8'h30, 1'b0);
		rd_chk(11'h7F0, 16);
	endtask : t_page
	// A partial page at zero, read from the top of the array across the wrap.
	task automatic t_partial();
		wr_page(11'h000, 2, 8'hC0, 1'b0);
		rd_chk(11'h7FE, 4);
	endtask : t_partial
	// With the lock high nothing is stored; an undriven lock allows writes.
	task automatic t_lock();
		@(posedge mclk);
		#1 wpDrv = 1'b1;
		wr_page(11'h000, 1, 8'h55, 1'b1);
		rd_chk(11'h000, 1);
		@(posedge mclk);
		#1 wpDrv = 1'bz;
		wr_page(11'h001, 1, 8'h66, 1'b0);
		rd_chk(11'h000, 2);
	endtask : t_lock
	// One write at 100 kHz, 400 kHz and 2 MHz, read back at the fastest.
	task automatic t_speeds();
		int spd [3] = '{5000, 1250, 250};
		for (int i = 0; i < 3; i++) begin
			i2c_ctrl_model_inst.halfNs = spd[i];
			wr_page(11'h100 + 11'(i), 1, 8'hA0 + 8'(i), 1'b0);
		end
		rd_chk(11'h100, 3);
	endtask : t_speeds
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	// Main sequence: reset for three cycles, let the synchronisers settle, then scenarios.
	initial begin
		rst_b = 1'b0;
		wpDrv = 1'b0;
		repeat (3) @(posedge mclk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge mclk);
		t_page();
		t_partial();
		t_lock();
		t_speeds();
		close_out();
	end
	// The scenarios need about 0.95 ms, nearly half of it the slowest speed; a hang is cut
	// off at 1.1 ms so that the run stays near its cycle budget.
	initial begin
		#1100000;
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
endmodule : two_wire_eeprom_bench
`default_nettype wire
